/* File: inc/vpr_pkg.sv */
package vpr_pkg;

	// Slot i holds the vector pair at VEC_BASE + 2*i; a higher slot wins.
	localparam int          NSLOT     = 64;
	localparam logic [15:0] VEC_BASE  = 16'hFF80;
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] VEC_WDOG  = 16'hFFFA;

	localparam logic [5:0] SLOT_ILLEGAL    = 6'h3C;
	localparam logic [5:0] SLOT_SWTRAP     = 6'h3B;
	localparam logic [5:0] SLOT_HIGH_LEVEL_EXT_IRQ       = 6'h3A;
	localparam logic [5:0] SLOT_UNMASK_LOW = 6'h3A;
	localparam logic [5:0] SLOT_PA_OVF     = 6'h2E;
	localparam logic [5:0] SLOT_PA_EDGE    = 6'h2D;
	localparam logic [5:0] SLOT_SERIAL     = 6'h2B;
	localparam logic [5:0] SLOT_USB_SETUP  = 6'h29;
	localparam logic [5:0] SLOT_USB_EPCFG  = 6'h28;
	localparam logic [5:0] SLOT_QUEUE_TOP  = 6'h1B;
	localparam logic [5:0] SLOT_DBUF_A_TOP = 6'h0F;
	localparam logic [5:0] SLOT_DBUF_B_TOP = 6'h0C;
	localparam logic [5:0] SLOT_CARD_STAT  = 6'h06;
	localparam logic [5:0] SLOT_CARD_CARD_IRQ_REQUEST  = 6'h05;
	localparam logic [5:0] SLOT_MEDIA_ERR  = 6'h02;
	localparam logic [5:0] SLOT_MEDIA_STAT = 6'h01;

	// Reserved slots: FFFC, FFD8, FFBC, FFBA, FF92, FF90, FF80.
	localparam logic [63:0] RESV_SET   = 64'h4000_1000_6000_0301;
	localparam logic [63:0] UNMASK_SET = 64'hFC00_0000_0000_0000;
	localparam logic [63:0] MASKABLE_SET = ~(RESV_SET | UNMASK_SET);

	// Register byte offsets on the APB side.
	localparam logic [7:0] ADDR_ENA_LO    = 8'h00;
	localparam logic [7:0] ADDR_ENA_HI    = 8'h04;
	localparam logic [7:0] ADDR_SERIAL    = 8'h08;
	localparam logic [7:0] ADDR_USB_SETUP = 8'h0C;
	localparam logic [7:0] ADDR_ELEVATE   = 8'h10;
	localparam logic [7:0] ADDR_PEND_LO   = 8'h14;
	localparam logic [7:0] ADDR_PEND_HI   = 8'h18;
	localparam logic [7:0] ADDR_VECTOR    = 8'h1C;
	localparam logic [7:0] ADDR_CAUSE     = 8'h20;
	localparam logic [7:0] ADDR_EVT_STS   = 8'h24;
	localparam logic [7:0] ADDR_EVT_MASK  = 8'h28;
	localparam logic [7:0] ADDR_MEDIA     = 8'h2C;
	localparam logic [7:0] RAM_BASE       = 8'h30;
	localparam logic [7:0] RAM_MASK       = 8'hF0;
	localparam int         RAM_WORDS      = 4;

	localparam int SERIAL_W = 4;
	localparam int USB_W    = 2;
	localparam int EVT_W    = 3;
	localparam int EVT_RESV = 0;
	localparam int EVT_ELEV = 1;
	localparam int EVT_ACK  = 2;
	localparam logic [7:0] ELEV_RESET = 8'h00;

	typedef enum logic [1:0] {
		CAUSE_POR  = 2'b01,
		CAUSE_WDOG = 2'b10
	} cause_t;

	function automatic logic [15:0] slot2vec(input logic [5:0] s);
		return VEC_BASE + {9'h000, s, 1'b0};
	endfunction : slot2vec

	// An elevate value is usable only when it names a maskable, unreserved slot.
	function automatic logic elevOk(input logic [7:0] v);
		return v[7] && !v[0] && MASKABLE_SET[v[6:1]];
	endfunction : elevOk

endpackage : vpr_pkg

/* File: inc/arb_if.sv */
`timescale 1ns/1ps
interface arb_if;
	logic [63:0] reqMask;
	logic [63:0] reqUnmask;
	logic [5:0]  elevSlot;
	logic        elevValid;
	logic        winValid;
	logic [5:0]  winSlot;
	modport arb (input reqMask, reqUnmask, elevSlot, elevValid, output winValid, winSlot);
	modport ctl (output reqMask, reqUnmask, elevSlot, elevValid, input winValid, winSlot);
endinterface : arb_if

/* File: logic/vpr_sync.sv */
`timescale 1ns/1ps
module vpr_sync #(
	parameter logic INIT = 1'b1
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Raw and filtered level
	input  wire logic din,
	output logic      q
);
	logic s1_r, s2_r, s3_r, q_r;

	// A change is taken only once the second and third stages agree.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
			q_r  <= INIT;
		end
		else
		begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				q_r <= s3_r;
		end
	end

	assign q = q_r;
endmodule : vpr_sync

/* File: logic/vpr_arbiter.sv */
`timescale 1ns/1ps
module vpr_arbiter (
	// Request vectors in, winner out
	arb_if.arb a
);
	// Order: unmaskable slots, then the elevated source, then the highest slot.
	always_comb
	begin
		a.winValid = 1'b0;
		a.winSlot  = 6'h00;
		for (int i = 0; i < vpr_pkg::NSLOT; i++)
		begin
			if (a.reqMask[i])
			begin
				a.winValid = 1'b1;
				a.winSlot  = 6'(i);
			end
		end
		if (a.elevValid && a.reqMask[a.elevSlot])
			a.winSlot = a.elevSlot;
		for (int j = 0; j < vpr_pkg::NSLOT; j++)
		begin
			if (a.reqUnmask[j])
			begin
				a.winValid = 1'b1;
				a.winSlot  = 6'(j);
			end
		end
	end
endmodule : vpr_arbiter

/* File: logic/vector_priority_reset_map.sv */
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - Higher vector wins; traps unmaskable; CPU_CONDITION_FLAGS gating.
// - Elevate value lifts one maskable source.
// - Pulse accumulator overflow and edge slots.
// - Serial port shares one vector, four enables.
// - USB setup events enabled by two bits.
// - Endpoint config request vector, own enable.
// - Four queue channels: full, empty, valid.
// - Double buffer pair A: three vectors.
// - Double buffer pair B: three vectors.
// - Card host: status and request vectors.
// - One media enable gates both vectors.
// - Power-on/pin reset first, watchdog second.
// - Any reset restores all start-up values, except vecByte, winSlot_r and the APB response registers, which only resetn clears.
// - RAM contents untouched by reset.
// - Needs local enable and CPU_CONDITION_FLAGS permission.
module vector_priority_reset_map (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Peripheral request conditions
	input  wire logic [63:0] srcCond,
	input  wire logic [3:0]  serialCond,
	input  wire logic [1:0]  usbSetupCond,
	// CPU core side
	input  wire logic        ccrIBit,
	input  wire logic        ccrXBit,
	input  wire logic        vecRd,
	input  wire logic        vecRdOdd,
	input  wire logic        intAck,
	output logic             irqToCore,
	output logic      [15:0] vecAddr,
	output logic      [7:0]  vecByte,
	output logic             vecIsReset,
	// Reset sources
	input  wire logic        extResetN,
	input  wire logic        watchdogTimeout,
	// Event interrupt
	output logic             evtIrq
);
	logic [31:0]          enaLo_r, enaHi_r;
	logic [3:0]           serialEn_r;
	logic [1:0]           usbEn_r;
	logic                 mediaEn_r;
	logic [7:0]           elev_r;
	logic [63:0]          pend_r, unm_r;
	logic [5:0]           winSlot_r;
	logic                 irqToCore_r, resetPend_r, vecIsReset_r;
	logic [15:0]          vecAddr_r, vecAddr_nxt;
	logic [7:0]           vecByte_r;
	vpr_pkg::cause_t      cause_r;
	logic [2:0]           evtSts_r, evtSts_nxt, evtMask_r, evtSet;
	logic                 evtIrq_r;
	logic [31:0]          prdata_r, rdMux;
	logic                 pready_r, pslverr_r, rdHit;
	logic [31:0]          ram [vpr_pkg::RAM_WORDS];
	logic [63:0]          condEff, enEff, gated;
	wire logic            pinLevel;
	arb_if                arbBus ();

	function automatic logic isRam(input logic [7:0] a);
		return (a & vpr_pkg::RAM_MASK) == vpr_pkg::RAM_BASE;
	endfunction : isRam

	vpr_sync #(
		.INIT (1'b1)
	) u_pin_sync (
		.clk    (clk),
		.resetn (resetn),
		.din    (extResetN),
		.q      (pinLevel)
	);

	vpr_arbiter u_arb (
		.a (arbBus.arb)
	);

	wire logic pinLow     = !pinLevel;
	wire logic softClear  = pinLow || watchdogTimeout;

	// APB decode; every access takes one wait state.
	wire logic apbAcc     = psel && penable && !pready_r;
	wire logic apbWr      = apbAcc && pwrite;
	wire logic apbRd      = apbAcc && !pwrite;
	wire logic wrEnaLo    = apbWr && (paddr == vpr_pkg::ADDR_ENA_LO);
	wire logic wrEnaHi    = apbWr && (paddr == vpr_pkg::ADDR_ENA_HI);
	wire logic wrSerial   = apbWr && (paddr == vpr_pkg::ADDR_SERIAL);
	wire logic wrUsb      = apbWr && (paddr == vpr_pkg::ADDR_USB_SETUP);
	wire logic wrElev     = apbWr && (paddr == vpr_pkg::ADDR_ELEVATE);
	wire logic wrEvtMask  = apbWr && (paddr == vpr_pkg::ADDR_EVT_MASK);
	wire logic wrMedia    = apbWr && (paddr == vpr_pkg::ADDR_MEDIA);
	wire logic wrRam      = apbWr && isRam(paddr);
	wire logic rdEvt      = apbRd && (paddr == vpr_pkg::ADDR_EVT_STS);
	wire logic [1:0] ramIdx = paddr[3:2];

	always_comb
	begin
		rdHit = 1'b1;
		if (paddr == vpr_pkg::ADDR_ENA_LO)
			rdMux = enaLo_r;
		else if (paddr == vpr_pkg::ADDR_ENA_HI)
			rdMux = enaHi_r;
		else if (paddr == vpr_pkg::ADDR_SERIAL)
			rdMux = {28'h0000000, serialEn_r};
		else if (paddr == vpr_pkg::ADDR_USB_SETUP)
			rdMux = {30'h00000000, usbEn_r};
		else if (paddr == vpr_pkg::ADDR_ELEVATE)
			rdMux = {24'h000000, elev_r};
		else if (paddr == vpr_pkg::ADDR_PEND_LO)
			rdMux = pend_r[31:0];
		else if (paddr == vpr_pkg::ADDR_PEND_HI)
			rdMux = pend_r[63:32];
		else if (paddr == vpr_pkg::ADDR_VECTOR)
			rdMux = {15'h0000, irqToCore_r, vecAddr_r};
		else if (paddr == vpr_pkg::ADDR_CAUSE)
			rdMux = {29'h00000000, resetPend_r, cause_r};
		else if (paddr == vpr_pkg::ADDR_EVT_STS)
			rdMux = {29'h00000000, evtSts_r};
		else if (paddr == vpr_pkg::ADDR_EVT_MASK)
			rdMux = {29'h00000000, evtMask_r};
		else if (paddr == vpr_pkg::ADDR_MEDIA)
			rdMux = {31'h00000000, mediaEn_r};
		else if (isRam(paddr))
			rdMux = ram[ramIdx];
		else
		begin
			rdMux = 32'h00000000;
			rdHit = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h00000000;
		end
		else
		begin
			pready_r  <= apbAcc;
			pslverr_r <= apbAcc && !rdHit;
			prdata_r  <= apbRd ? rdMux : 32'h00000000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (wrRam)
			ram[ramIdx] <= pwdata;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			enaLo_r    <= 32'h00000000;
			enaHi_r    <= 32'h00000000;
			serialEn_r <= 4'h0;
			usbEn_r    <= 2'h0;
			mediaEn_r  <= 1'b0;
			elev_r     <= vpr_pkg::ELEV_RESET;
			evtMask_r  <= 3'h0;
		end
		else if (softClear)
		begin
			enaLo_r    <= 32'h00000000;
			enaHi_r    <= 32'h00000000;
			serialEn_r <= 4'h0;
			usbEn_r    <= 2'h0;
			mediaEn_r  <= 1'b0;
			elev_r     <= vpr_pkg::ELEV_RESET;
			evtMask_r  <= 3'h0;
		end
		else
		begin
			if (wrEnaLo)
				enaLo_r <= pwdata;
			if (wrEnaHi)
				enaHi_r <= pwdata;
			if (wrSerial)
				serialEn_r <= pwdata[vpr_pkg::SERIAL_W-1:0];
			if (wrUsb)
				usbEn_r <= pwdata[vpr_pkg::USB_W-1:0];
			if (wrMedia)
				mediaEn_r <= pwdata[0];
			if (wrElev)
				elev_r <= pwdata[7:0];
			if (wrEvtMask)
				evtMask_r <= pwdata[vpr_pkg::EVT_W-1:0];
		end
	end

	// Shared vectors fold their sub-conditions into one slot request.
	always_comb
	begin
		condEff = srcCond;
		condEff[vpr_pkg::SLOT_SERIAL]    = |(serialCond & serialEn_r);
		condEff[vpr_pkg::SLOT_USB_SETUP] = |(usbSetupCond & usbEn_r);
		enEff = {enaHi_r, enaLo_r};
		enEff[vpr_pkg::SLOT_SERIAL]     = 1'b1;
		enEff[vpr_pkg::SLOT_USB_SETUP]  = 1'b1;
		enEff[vpr_pkg::SLOT_MEDIA_ERR]  = mediaEn_r;
		enEff[vpr_pkg::SLOT_MEDIA_STAT] = mediaEn_r;
	end

	assign gated = condEff & enEff & vpr_pkg::MASKABLE_SET;

	// only the two traps and HIGH_LEVEL_EXT_IRQ are unmaskable; reset slots never request.
	wire logic [63:0] trapSet = (64'h1 << vpr_pkg::SLOT_ILLEGAL) |
		(64'h1 << vpr_pkg::SLOT_SWTRAP) | (64'h1 << vpr_pkg::SLOT_HIGH_LEVEL_EXT_IRQ);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pend_r <= 64'h0000000000000000;
			unm_r  <= 64'h0000000000000000;
		end
		else if (softClear)
		begin
			pend_r <= 64'h0000000000000000;
			unm_r  <= 64'h0000000000000000;
		end
		else
		begin
			pend_r <= gated;
			unm_r  <= (srcCond & trapSet) &
				~((ccrXBit ? 64'h1 : 64'h0) << vpr_pkg::SLOT_HIGH_LEVEL_EXT_IRQ);
		end
	end

	assign arbBus.reqMask   = pend_r & {64{!ccrIBit}};
	assign arbBus.reqUnmask = unm_r;
	assign arbBus.elevValid = vpr_pkg::elevOk(elev_r);
	assign arbBus.elevSlot  = elev_r[6:1];

	assign vecAddr_nxt = resetPend_r ?
		((cause_r == vpr_pkg::CAUSE_WDOG) ? vpr_pkg::VEC_WDOG : vpr_pkg::VEC_RESET) :
		vpr_pkg::slot2vec(arbBus.winSlot);

	// A reset fetch completes on the odd-byte read; the pending flag guards it.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cause_r     <= vpr_pkg::CAUSE_POR;
			resetPend_r <= 1'b1;
		end
		else if (softClear)
		begin
			cause_r     <= pinLow ? vpr_pkg::CAUSE_POR : vpr_pkg::CAUSE_WDOG;
			resetPend_r <= 1'b1;
		end
		else if (vecRd && vecRdOdd)
			resetPend_r <= 1'b0;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			irqToCore_r  <= 1'b0;
			winSlot_r    <= 6'h00;
			vecAddr_r    <= vpr_pkg::VEC_RESET;
			vecIsReset_r <= 1'b1;
		end
		else
		begin
			irqToCore_r  <= arbBus.winValid && !resetPend_r && !softClear;
			winSlot_r    <= arbBus.winSlot;
			vecAddr_r    <= vecAddr_nxt;
			vecIsReset_r <= resetPend_r;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			vecByte_r <= 8'h00;
		else if (vecRd)
			vecByte_r <= vecRdOdd ? vecAddr_r[7:0] : vecAddr_r[15:8];
	end

	// A set arriving with the clearing read survives it.
	assign evtSet[vpr_pkg::EVT_RESV] = |(srcCond & vpr_pkg::RESV_SET);
	assign evtSet[vpr_pkg::EVT_ELEV] = wrElev && !vpr_pkg::elevOk(pwdata[7:0]);
	assign evtSet[vpr_pkg::EVT_ACK]  = intAck;
	assign evtSts_nxt = (rdEvt ? 3'h0 : evtSts_r) | evtSet;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			evtSts_r <= 3'h0;
			evtIrq_r <= 1'b0;
		end
		else
		begin
			evtSts_r <= softClear ? 3'h0 : evtSts_nxt;
			evtIrq_r <= !softClear && |(evtSts_nxt & evtMask_r);
		end
	end

	assign prdata     = prdata_r;
	assign pready     = pready_r;
	assign pslverr    = pslverr_r;
	assign irqToCore  = irqToCore_r;
	assign vecAddr    = vecAddr_r;
	assign vecByte    = vecByte_r;
	assign vecIsReset = vecIsReset_r;
	assign evtIrq     = evtIrq_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_prio;
		arbBus.winValid && arbBus.reqUnmask == 64'h0 &&
		!(arbBus.elevValid && arbBus.reqMask[arbBus.elevSlot]) |->
		(arbBus.reqMask >> arbBus.winSlot) == 64'h1;
	endproperty
	a_prio: assert property (p_prio) else $error("lower slot won");

	property p_ccr;
		ccrIBit && unm_r == 64'h0 |=> !irqToCore_r;
	endproperty
	a_ccr: assert property (p_ccr) else $error("masked request reached core");

	property p_elev;
		arbBus.elevValid && arbBus.reqMask[arbBus.elevSlot] && arbBus.reqUnmask == 64'h0
		|-> arbBus.winSlot == arbBus.elevSlot;
	endproperty
	a_elev: assert property (p_elev) else $error("elevated source lost");

	property p_resv;
		irqToCore_r |-> !vpr_pkg::RESV_SET[winSlot_r];
	endproperty
	a_resv: assert property (p_resv) else $error("reserved slot requested");

	property p_pa;
		!softClear && srcCond[vpr_pkg::SLOT_PA_OVF] && enEff[vpr_pkg::SLOT_PA_OVF]
		|=> pend_r[vpr_pkg::SLOT_PA_OVF];
	endproperty
	a_pa: assert property (p_pa) else $error("overflow request missing");

	property p_serial;
		!softClear && |(serialCond & serialEn_r) |=> pend_r[vpr_pkg::SLOT_SERIAL];
	endproperty
	a_serial: assert property (p_serial) else $error("serial request missing");

	property p_media;
		!mediaEn_r |=> !pend_r[vpr_pkg::SLOT_MEDIA_ERR] && !pend_r[vpr_pkg::SLOT_MEDIA_STAT];
	endproperty
	a_media: assert property (p_media) else $error("media request without enable");

	property p_wdog;
		watchdogTimeout && !pinLow ##1 !softClear |=> vecAddr_r == vpr_pkg::VEC_WDOG;
	endproperty
	a_wdog: assert property (p_wdog) else $error("wrong watchdog vector");

	property p_clear;
		softClear |=> enaLo_r == 32'h0 && elev_r == vpr_pkg::ELEV_RESET && !irqToCore_r;
	endproperty
	a_clear: assert property (p_clear) else $error("state kept over reset");

	property p_byte;
		vecRd && !vecRdOdd |=> vecByte_r == $past(vecAddr_r[15:8]);
	endproperty
	a_byte: assert property (p_byte) else $error("even byte not high half");

	c_irq:  cover property (irqToCore_r ##1 vecRd ##2 (vecRd && vecRdOdd));
	c_elev: cover property (arbBus.elevValid && arbBus.reqMask[arbBus.elevSlot]);
	c_wdog: cover property (watchdogTimeout && !pinLow);
endmodule : vector_priority_reset_map

/* File: verif/cpu_fetch_model.sv */
`timescale 1ns/1ps
// Core model: reads the vector pair high byte first and may stall before the low byte.
module cpu_fetch_model (
	// Clock and bench control
	input  wire logic       clk,
	input  wire logic       fetchGo,
	input  wire logic       slowMode,
	input  wire logic       doAck,
	// Block side
	input  wire logic [7:0] vecByte,
	output logic            vecRd,
	output logic            vecRdOdd,
	output logic            intAck,
	output logic [15:0]     fetched,
	output logic            fetchDone
);
	logic [7:0] hiByte;

	initial
	begin
		vecRd = 1'b0;
		vecRdOdd = 1'b0;
		intAck = 1'b0;
		fetched = 16'h0000;
		fetchDone = 1'b0;
		hiByte = 8'h00;
		forever
		begin
			@(posedge clk);
			fetchDone <= 1'b0;
			intAck <= 1'b0;
			if (fetchGo)
			begin
				vecRd <= 1'b1;
				vecRdOdd <= 1'b0;
				@(posedge clk);
				vecRd <= 1'b0;
				@(posedge clk);
				hiByte = vecByte;
				if (slowMode)
					repeat (3) @(posedge clk);
				vecRd <= 1'b1;
				vecRdOdd <= 1'b1;
				@(posedge clk);
				vecRd <= 1'b0;
				vecRdOdd <= 1'b0;
				@(posedge clk);
				fetched <= {hiByte, vecByte};
				fetchDone <= 1'b1;
				intAck <= doAck;
			end
		end
	end
endmodule : cpu_fetch_model

/* File: verif/vector_priority_reset_map_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		checked++; \
		if ((g) !== (e)) \
		begin \
			nErrors++; \
			$display("BAD %0t %m got %0h expected %0h", $time, (g), (e)); \
		end \
	end
module vector_priority_reset_map_tb;
	logic        clk;
	logic        resetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [63:0] srcCond;
	logic [3:0]  serialCond;
	logic [1:0]  usbSetupCond;
	logic        ccrIBit;
	logic        ccrXBit;
	logic        vecRd;
	logic        vecRdOdd;
	logic        intAck;
	logic        irqToCore;
	logic [15:0] vecAddr;
	logic [7:0]  vecByte;
	logic        vecIsReset;
	logic        extResetN;
	logic        watchdogTimeout;
	logic        evtIrq;
	logic        fetchGo;
	logic        slowMode;
	logic        doAck;
	logic [15:0] fetched;
	logic        fetchDone;
	logic [31:0] rdData;
	logic        rdErr;
	int          nErrors;
	int          checked;

	vector_priority_reset_map u_dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .srcCond, .serialCond, .usbSetupCond, .ccrIBit, .ccrXBit,
		.vecRd, .vecRdOdd, .intAck, .irqToCore, .vecAddr, .vecByte, .vecIsReset, .extResetN,
		.watchdogTimeout, .evtIrq);
	cpu_fetch_model u_core (.clk, .fetchGo, .slowMode, .doAck, .vecByte, .vecRd, .vecRdOdd,
		.intAck, .fetched, .fetchDone);

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, nErrors);
		if (nErrors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		`CHK(n < 20, 1'b1)
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(rdData, e)
	endtask : rdChk

	task automatic drv(input logic [63:0] s, input logic [3:0] sc, input logic [1:0] us);
		@(posedge clk);
		srcCond <= s;
		serialCond <= sc;
		usbSetupCond <= us;
		repeat (3) @(posedge clk);
		#1;
	endtask : drv

	task automatic irqIs(input logic i, input logic [15:0] v);
		`CHK(irqToCore, i)
		if (i)
			`CHK(vecAddr, v)
	endtask : irqIs

	task automatic fetch(input logic slow, input logic ack, input logic [15:0] v);
		int n;
		@(posedge clk);
		slowMode <= slow;
		doAck <= ack;
		fetchGo <= 1'b1;
		@(posedge clk);
		fetchGo <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (fetchDone !== 1'b1 && n < 30);
		`CHK(n < 30, 1'b1)
		`CHK(fetched, v)
	endtask : fetch

	task automatic t_reset;
		logic [7:0] zr [7];
		zr = '{vpr_pkg::ADDR_ENA_LO, vpr_pkg::ADDR_ENA_HI, vpr_pkg::ADDR_SERIAL,
			vpr_pkg::ADDR_USB_SETUP, vpr_pkg::ADDR_ELEVATE, vpr_pkg::ADDR_MEDIA,
			vpr_pkg::ADDR_PEND_LO};
		#1;
		`CHK(vecIsReset, 1'b1)
		`CHK(vecAddr, 16'hFFFE)
		`CHK(irqToCore, 1'b0)
		foreach (zr[k])
			rdChk(zr[k], 32'h0000_0000);
		rdChk(vpr_pkg::ADDR_CAUSE, 32'h0000_0005);
		fetch(1'b1, 1'b0, 16'hFFFE);
		rdChk(vpr_pkg::ADDR_CAUSE, 32'h0000_0001);
		`CHK(vecIsReset, 1'b0)
		$display("test reset done");
	endtask : t_reset

	task automatic t_sources;
		logic [63:0] one;
		drv(64'h03FF_FFFF_FFFF_FFF8, 4'h0, 2'h0);
		irqIs(1'b0, 16'h0000);
		for (int s = 3; s < 58; s++)
		begin
			if (s inside {8, 9, 29, 30, 41, 43, 44})
				continue;
			one = 64'h0000_0000_0000_0001 << s;
			wr(vpr_pkg::ADDR_ENA_LO, one[31:0]);
			wr(vpr_pkg::ADDR_ENA_HI, one[63:32]);
			drv(one, 4'h0, 2'h0);
			irqIs(1'b1, 16'hFF80 + 16'(2 * s));
			@(posedge clk);
			ccrIBit <= 1'b1;
			repeat (2) @(posedge clk);
			#1;
			`CHK(irqToCore, 1'b0)
			@(posedge clk);
			ccrIBit <= 1'b0;
		end
		$display("test sources done");
	endtask : t_sources

	task automatic t_priority;
		wr(vpr_pkg::ADDR_ENA_LO, 32'hFFFF_FFFF);
		wr(vpr_pkg::ADDR_ENA_HI, 32'hFFFF_FFFF);
		drv(64'h0000_4000_0000_0400, 4'h0, 2'h0);
		irqIs(1'b1, 16'hFFDC);
		rdChk(vpr_pkg::ADDR_VECTOR, 32'h0001_FFDC);
		drv(64'h0400_4000_0000_0400, 4'h0, 2'h0);
		irqIs(1'b1, 16'hFFF4);
		@(posedge clk);
		ccrXBit <= 1'b1;
		drv(64'h0400_4000_0000_0400, 4'h0, 2'h0);
		irqIs(1'b1, 16'hFFDC);
		@(posedge clk);
		ccrIBit <= 1'b1;
		drv(64'h1800_4000_0000_0000, 4'h0, 2'h0);
		irqIs(1'b1, 16'hFFF8);
		fetch(1'b0, 1'b1, 16'hFFF8);
		@(posedge clk);
		ccrIBit <= 1'b0;
		ccrXBit <= 1'b0;
		wr(vpr_pkg::ADDR_ELEVATE, 32'h0000_00DC);
		drv(64'h0200_4000_0000_0000, 4'h0, 2'h0);
		irqIs(1'b1, 16'hFFDC);
		drv(64'h0600_4000_0000_0000, 4'h0, 2'h0);
		irqIs(1'b1, 16'hFFF4);
		wr(vpr_pkg::ADDR_ELEVATE, 32'h0000_00F2);
		drv(64'h0200_4000_0000_0000, 4'h0, 2'h0);
		irqIs(1'b1, 16'hFFF2);
		wr(vpr_pkg::ADDR_ELEVATE, 32'h0000_0000);
		$display("test priority done");
	endtask : t_priority

	task automatic t_periph;
		for (int i = 0; i < 4; i++)
		begin
			wr(vpr_pkg::ADDR_SERIAL, 32'(1 << i));
			drv(64'h0, 4'hF ^ 4'(1 << i), 2'h0);
			irqIs(1'b0, 16'h0000);
			drv(64'h0, 4'(1 << i), 2'h0);
			irqIs(1'b1, 16'hFFD6);
		end
		for (int i = 0; i < 2; i++)
		begin
			wr(vpr_pkg::ADDR_USB_SETUP, 32'(1 << i));
			drv(64'h0, 4'h0, 2'h3 ^ 2'(1 << i));
			irqIs(1'b0, 16'h0000);
			drv(64'h0, 4'h0, 2'(1 << i));
			irqIs(1'b1, 16'hFFD2);
		end
		drv(64'h6, 4'h0, 2'h0);
		irqIs(1'b0, 16'h0000);
		wr(vpr_pkg::ADDR_MEDIA, 32'h0000_0001);
		drv(64'h6, 4'h0, 2'h0);
		irqIs(1'b1, 16'hFF84);
		drv(64'h2, 4'h0, 2'h0);
		irqIs(1'b1, 16'hFF82);
		$display("test peripherals done");
	endtask : t_periph

	task automatic t_events;
		wr(vpr_pkg::ADDR_EVT_MASK, 32'h0000_0000);
		apb(1'b0, vpr_pkg::ADDR_EVT_STS, 32'h0000_0000);
		drv(64'h0000_1000_4000_0001, 4'h0, 2'h0);
		irqIs(1'b0, 16'h0000);
		`CHK(evtIrq, 1'b0)
		wr(vpr_pkg::ADDR_EVT_MASK, 32'h0000_0007);
		repeat (2) @(posedge clk);
		#1;
		`CHK(evtIrq, 1'b1)
		wr(vpr_pkg::ADDR_ELEVATE, 32'h0000_00D8);
		drv(64'h0800_0000_0000_0000, 4'h0, 2'h0);
		irqIs(1'b1, 16'hFFF6);
		fetch(1'b0, 1'b1, 16'hFFF6);
		drv(64'h0, 4'h0, 2'h0);
		apb(1'b0, vpr_pkg::ADDR_EVT_STS, 32'h0000_0000);
		`CHK(rdData[2:0], 3'b111)
		rdChk(vpr_pkg::ADDR_EVT_STS, 32'h0000_0000);
		repeat (2) @(posedge clk);
		#1;
		`CHK(evtIrq, 1'b0)
		$display("test events done");
	endtask : t_events

	task automatic t_resets;
		wr(vpr_pkg::ADDR_ENA_LO, 32'h0000_F000);
		wr(vpr_pkg::ADDR_ELEVATE, 32'h0000_00DC);
		wr(vpr_pkg::RAM_BASE, 32'hA5C3_0F96);
		@(posedge clk);
		watchdogTimeout <= 1'b1;
		// The watchdog reset is a one-cycle pulse; a held level would block later writes.
		@(posedge clk);
		watchdogTimeout <= 1'b0;
		drv(64'h0, 4'h0, 2'h0);
		`CHK(vecAddr, 16'hFFFA)
		`CHK(vecIsReset, 1'b1)
		rdChk(vpr_pkg::ADDR_CAUSE, 32'h0000_0006);
		rdChk(vpr_pkg::ADDR_ENA_LO, 32'h0000_0000);
		rdChk(vpr_pkg::ADDR_ELEVATE, 32'h0000_0000);
		rdChk(vpr_pkg::RAM_BASE, 32'hA5C3_0F96);
		fetch(1'b0, 1'b0, 16'hFFFA);
		wr(vpr_pkg::ADDR_ENA_HI, 32'h0000_0001);
		@(posedge clk);
		extResetN <= 1'b0;
		watchdogTimeout <= 1'b1;
		@(posedge clk);
		watchdogTimeout <= 1'b0;
		repeat (8) @(posedge clk);
		extResetN <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		`CHK(vecAddr, 16'hFFFE)
		rdChk(vpr_pkg::ADDR_CAUSE, 32'h0000_0005);
		rdChk(vpr_pkg::ADDR_ENA_HI, 32'h0000_0000);
		rdChk(vpr_pkg::RAM_BASE, 32'hA5C3_0F96);
		fetch(1'b0, 1'b0, 16'hFFFE);
		apb(1'b0, 8'h44, 32'h0000_0000);
		`CHK({rdErr, rdData}, 33'h1_0000_0000)
		apb(1'b1, 8'h48, 32'h1234_5678);
		`CHK(rdErr, 1'b1)
		$display("test resets done");
	endtask : t_resets

	initial
	begin
		nErrors = 0;
		checked = 0;
		resetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{srcCond, serialCond, usbSetupCond, ccrIBit, ccrXBit} = '0;
		{extResetN, watchdogTimeout, fetchGo, slowMode, doAck} = 5'b10000;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		t_reset;
		t_sources;
		t_priority;
		t_periph;
		t_events;
		t_resets;
		print_verdict;
	end

	initial
	begin
		#1_000_000;
		nErrors++;
		$display("BAD %0t run did not finish", $time);
		print_verdict;
	end
endmodule : vector_priority_reset_map_tb
